// ### design/cmp_div_pkg.sv
// Package with encodings, field positions and carrier types for the compare/divide unit
package cmp_div_pkg;
    localparam int          DATA_W        = 32;
    localparam int          IMM_W         = 16;
    // Instruction word field positions
    localparam int          FLD_A_LSB     = 27;
    localparam int          FLD_B_LSB     = 22;
    localparam int          FLD_C_LSB     = 17;
    localparam int          FLD_X_LSB     = 11;
    localparam int          FLD_X_W       = 6;
    localparam int          FLD_N_LSB     = 6;
    localparam int          FLD_N_W       = 8;
    localparam int          FLD_IMM_LSB   = 6;
    localparam int          FLD_RA_SEL    = 16;
    localparam int          FLD_RB_SEL    = 15;
    localparam int          FLD_WC_SEL    = 14;
    localparam int          REG_IDX_W     = 5;
    // Primary opcodes
    localparam logic [5:0]  OP_RTYPE      = 6'h3A;
    localparam logic [5:0]  OP_CMPLTI     = 6'h10;
    localparam logic [5:0]  OP_CMPLTUI    = 6'h30;
    localparam logic [5:0]  OP_CMPNEI     = 6'h18;
    localparam logic [5:0]  OP_CUSTOM     = 6'h32;
    // Extended opcodes under the register-form primary opcode
    localparam logic [5:0]  XOP_CMPLT     = 6'h10;
    localparam logic [5:0]  XOP_CMPLTU    = 6'h30;
    localparam logic [5:0]  XOP_CMPNE     = 6'h18;
    localparam logic [5:0]  XOP_DIV       = 6'h25;
    localparam logic [5:0]  XOP_DIVU      = 6'h24;
    // Divider takes one cycle per quotient bit
    localparam logic [5:0]  DIV_STEPS     = 6'h20;
    localparam logic [31:0] ZERO32        = 32'h0000_0000;

    // Issue from decode: word plus both operand values
    typedef struct packed {
        logic [31:0] word;
        logic [31:0] opa;
        logic [31:0] opb;
    } issue_type;

    // Write-back toward the register file
    typedef struct packed {
        logic [4:0]  dst;
        logic [31:0] data;
        logic        wr;
        logic        unimpl;
    } result_type;

    // Dispatch toward the custom logic
    typedef struct packed {
        logic [7:0]  sel;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [4:0]  ia;
        logic [4:0]  ib;
        logic [4:0]  ic;
        logic        gpa;
        logic        gpb;
        logic        gpc;
    } cust_req_type;

    typedef enum logic [1:0] {
        IDLE,
        DIVIDE,
        CUSTOM
    } state_type;
endpackage

// ### design/compare_divide_custom_exec.sv
// Compare, custom-instruction dispatch and divide execution slice
`timescale 1ns/100ps

// Notes on behaviour
// RL1 - Register signed less-than writes 1 when first below second, else 0.
// RL2 - Register unsigned less-than writes 1 when first below second unsigned.
// RL3 - Register not-equal writes 1 when the two sources differ.
// RL4 - Immediate signed less-than sign-extends immediate, result to second field.
// RL5 - Immediate unsigned less-than zero-extends immediate, result to second field.
// RL6 - Immediate not-equal sign-extends immediate, result to second field.
// RL7 - Custom opcode carries an eight-bit selector for up to 256 operations.
// RL8 - Custom gets two operands; result written only when custom logic gives one.
// RL9 - Per-field select bit picks general or custom register file.
// RL10 - Unsigned divide writes integer quotient of first over second.
// RL11 - Unsigned divide by zero leaves any value, raises no exception.
// RL12 - Without unsigned divide hardware, executing it flags unimplemented instruction.
// RL13 - Signed divide truncates toward zero; odd cases undefined; absent flags unimplemented.
// RL14 - Register fields from top down, extended opcode, unused, primary opcode low.
module compare_divide_custom_exec
    import cmp_div_pkg::*;
#(
    parameter bit HAS_DIVU = 1'b1,
    parameter bit HAS_DIV  = 1'b1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         issue_valid,
    input  wire issue_type    issue,
    output logic              busy,
    output result_type        result,
    output logic              cust_start,
    output cust_req_type      cust_req,
    input  wire logic         cust_done,
    input  wire logic         cust_has_result,
    input  wire logic [31:0]  cust_result
);

    // Field extraction from the instruction word [RL14]
    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction

    logic [5:0]  op;
    logic [5:0]  xop;
    logic [4:0]  fa;
    logic [4:0]  fb;
    logic [4:0]  fc;
    logic [15:0] imm;
    assign op  = issue.word[5:0];
    assign xop = issue.word[FLD_X_LSB +: FLD_X_W];
    assign fa  = issue.word[FLD_A_LSB +: REG_IDX_W];
    assign fb  = issue.word[FLD_B_LSB +: REG_IDX_W];
    assign fc  = issue.word[FLD_C_LSB +: REG_IDX_W];
    assign imm = issue.word[FLD_IMM_LSB +: IMM_W];

    state_type    state_ff;
    state_type    nxt_state;
    result_type   result_ff;
    result_type   nxt_result;
    logic         cstart_ff;
    logic         nxt_cstart;
    cust_req_type creq_ff;
    cust_req_type nxt_creq;
    logic [31:0]  quo_ff;
    logic [31:0]  nxt_quo;
    logic [32:0]  rem_ff;
    logic [32:0]  nxt_rem;
    logic [31:0]  dvs_ff;
    logic [31:0]  nxt_dvs;
    logic [5:0]   cnt_ff;
    logic [5:0]   nxt_cnt;
    logic         neg_ff;
    logic         nxt_neg;
    logic [4:0]   dst_ff;
    logic [4:0]   nxt_dst;
    logic         busy_ff;
    logic         nxt_busy;

    // Next-state: decode, compare, divide iteration and custom handshake
    always_comb begin
        logic [32:0] trial;
        logic [31:0] abs_a;
        logic [31:0] abs_b;
        trial      = 33'h0_0000_0000;
        abs_a      = issue.opa;
        abs_b      = issue.opb;
        nxt_state  = state_ff;
        nxt_result = result_ff;
        nxt_result.wr     = 1'b0;
        nxt_result.unimpl = 1'b0;
        nxt_cstart = 1'b0;
        nxt_creq   = creq_ff;
        nxt_quo    = quo_ff;
        nxt_rem    = rem_ff;
        nxt_dvs    = dvs_ff;
        nxt_cnt    = cnt_ff;
        nxt_neg    = neg_ff;
        nxt_dst    = dst_ff;
        case (state_ff)
            IDLE: begin
                if (issue_valid) begin
                    if (op == OP_RTYPE) begin
                        nxt_result.dst = fc;
                        if (xop == XOP_CMPLT) begin
                            nxt_result.data = {31'h0000_0000,
                                $signed(issue.opa) < $signed(issue.opb)}; // [RL1]
                            nxt_result.wr   = 1'b1;
                        end else if (xop == XOP_CMPLTU) begin
                            nxt_result.data = {31'h0000_0000, issue.opa < issue.opb}; // [RL2]
                            nxt_result.wr   = 1'b1;
                        end else if (xop == XOP_CMPNE) begin
                            nxt_result.data = {31'h0000_0000, issue.opa != issue.opb}; // [RL3]
                            nxt_result.wr   = 1'b1;
                        end else if (xop == XOP_DIVU) begin
                            if (HAS_DIVU) begin
                                nxt_quo   = issue.opa; // [RL10]
                                nxt_dvs   = issue.opb;
                                nxt_rem   = 33'h0_0000_0000;
                                nxt_neg   = 1'b0;
                                nxt_cnt   = DIV_STEPS;
                                nxt_dst   = fc;
                                nxt_state = DIVIDE;
                            end else begin
                                nxt_result.unimpl = 1'b1; // [RL12]
                            end
                        end else if (xop == XOP_DIV) begin
                            if (HAS_DIV) begin
                                if (issue.opa[31]) abs_a = ZERO32 - issue.opa;
                                if (issue.opb[31]) abs_b = ZERO32 - issue.opb;
                                nxt_quo   = abs_a; // [RL13]
                                nxt_dvs   = abs_b;
                                nxt_rem   = 33'h0_0000_0000;
                                nxt_neg   = issue.opa[31] ^ issue.opb[31];
                                nxt_cnt   = DIV_STEPS;
                                nxt_dst   = fc;
                                nxt_state = DIVIDE;
                            end else begin
                                nxt_result.unimpl = 1'b1; // [RL13]
                            end
                        end
                    end else if (op == OP_CMPLTI) begin
                        nxt_result.dst  = fb;
                        nxt_result.data = {31'h0000_0000,
                            $signed(issue.opa) < $signed(sext16(imm))}; // [RL4]
                        nxt_result.wr   = 1'b1;
                    end else if (op == OP_CMPLTUI) begin
                        nxt_result.dst  = fb;
                        nxt_result.data = {31'h0000_0000,
                            issue.opa < {16'h0000, imm}}; // [RL5]
                        nxt_result.wr   = 1'b1;
                    end else if (op == OP_CMPNEI) begin
                        nxt_result.dst  = fb;
                        nxt_result.data = {31'h0000_0000, issue.opa != sext16(imm)}; // [RL6]
                        nxt_result.wr   = 1'b1;
                    end else if (op == OP_CUSTOM) begin
                        nxt_creq.sel = issue.word[FLD_N_LSB +: FLD_N_W]; // [RL7]
                        nxt_creq.opa = issue.opa; // [RL8]
                        nxt_creq.opb = issue.opb;
                        nxt_creq.ia  = fa;
                        nxt_creq.ib  = fb;
                        nxt_creq.ic  = fc;
                        nxt_creq.gpa = issue.word[FLD_RA_SEL]; // [RL9]
                        nxt_creq.gpb = issue.word[FLD_RB_SEL]; // [RL9]
                        nxt_creq.gpc = issue.word[FLD_WC_SEL]; // [RL9]
                        nxt_cstart   = 1'b1;
                        nxt_state    = CUSTOM;
                    end
                end
            end
            DIVIDE: begin
                // Restoring division, one quotient bit per cycle; zero divisor gives an all-ones quotient, written as 1 for a negative signed dividend
                trial   = {rem_ff[31:0], quo_ff[31]} - {1'b0, dvs_ff}; // [RL11]
                if (trial[32]) begin
                    nxt_rem = {rem_ff[31:0], quo_ff[31]};
                    nxt_quo = {quo_ff[30:0], 1'b0};
                end else begin
                    nxt_rem = trial;
                    nxt_quo = {quo_ff[30:0], 1'b1};
                end
                nxt_cnt = cnt_ff - 6'h01;
                if (cnt_ff == 6'h01) begin
                    nxt_result.dst  = dst_ff;
                    nxt_result.data = neg_ff ? ZERO32 - nxt_quo : nxt_quo; // [RL13]
                    nxt_result.wr   = 1'b1;
                    nxt_state       = IDLE;
                end
            end
            CUSTOM: begin
                if (cust_done) begin
                    nxt_result.dst  = creq_ff.ic;
                    nxt_result.data = cust_result;
                    nxt_result.wr   = cust_has_result & creq_ff.gpc; // [RL8] [RL9]
                    nxt_state       = IDLE;
                end
            end
            default: nxt_state = IDLE;
        endcase
        // Busy in every cycle the unit cannot take an issue
        nxt_busy = (nxt_state != IDLE);
    end

    // State registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff  <= IDLE;
            result_ff <= '0;
            cstart_ff <= 1'b0;
            creq_ff   <= '0;
            quo_ff    <= 32'h0000_0000;
            rem_ff    <= 33'h0_0000_0000;
            dvs_ff    <= 32'h0000_0000;
            cnt_ff    <= 6'h00;
            neg_ff    <= 1'b0;
            dst_ff    <= 5'h00;
            busy_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            result_ff <= nxt_result;
            cstart_ff <= nxt_cstart;
            creq_ff   <= nxt_creq;
            quo_ff    <= nxt_quo;
            rem_ff    <= nxt_rem;
            dvs_ff    <= nxt_dvs;
            cnt_ff    <= nxt_cnt;
            neg_ff    <= nxt_neg;
            dst_ff    <= nxt_dst;
            busy_ff   <= nxt_busy;
        end
    end

    assign busy       = busy_ff;
    assign result     = result_ff;
    assign cust_start = cstart_ff;
    assign cust_req   = creq_ff;

endmodule

// ### bench/cmp_div_monitor.sv
// Port checker for the compare, divide and custom dispatch unit
`timescale 1ns/100ps
module cmp_div_monitor
    import cmp_div_pkg::*;
#(
    parameter bit HAS_DIVU = 1'b1,
    parameter bit HAS_DIV  = 1'b1
) (
    input wire logic         clk,
    input wire logic         rst_b,
    input wire logic         issue_valid,
    input wire issue_type    issue,
    input wire logic         busy,
    input wire result_type   result,
    input wire logic         cust_start,
    input wire cust_req_type cust_req,
    input wire logic         cust_done,
    input wire logic         cust_has_result,
    input wire logic [31:0]  cust_result
);
    // Decoded view of a taken word and the expected compare bits
    wire logic        tk = issue_valid && !busy;
    wire logic        rt = tk && issue.word[5:0] == OP_RTYPE;
    wire logic [5:0]  op = issue.word[5:0];
    wire logic [5:0]  xo = issue.word[16:11];
    wire logic [31:0] si = {{16{issue.word[21]}}, issue.word[21:6]};
    wire logic [31:0] zi = {16'h0000, issue.word[21:6]};
    wire logic        lt = $signed(issue.opa) < $signed(issue.opb);
    wire logic        lu = issue.opa < issue.opb;
    wire logic        li = $signed(issue.opa) < $signed(si);
    wire logic        lz = issue.opa < zi;
    wire logic        ni = issue.opa != si;
    wire logic        wp = cust_has_result && cust_req.gpc;
    wire logic        ne = issue.opa != issue.opb;
    wire logic [31:0] sq = $signed(issue.opa) / $signed(issue.opb);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_reg_lt_signed: assert property (rt && xo == XOP_CMPLT |=> result.wr
        && result.data == {31'h0, $past(lt)} && result.dst == $past(issue.word[21:17]))
        else $error("signed compare wrong");
    chk_reg_lt_unsigned: assert property (rt && xo == XOP_CMPLTU |=> result.wr
        && result.data == {31'h0, $past(lu)}) else $error("unsigned compare wrong");
    chk_imm_lt_signed: assert property (tk && op == OP_CMPLTI |=> result.wr
        && result.data == {31'h0, $past(li)} && result.dst == $past(issue.word[26:22]))
        else $error("signed immediate compare wrong");
    chk_imm_lt_unsigned: assert property (tk && op == OP_CMPLTUI |=> result.wr
        && result.data == {31'h0, $past(lz)}) else $error("unsigned immediate compare wrong");
    chk_imm_not_equal: assert property (tk && op == OP_CMPNEI |=> result.wr
        && result.data == {31'h0, $past(ni)}) else $error("immediate not-equal wrong");
    chk_divu_quotient: assert property (HAS_DIVU && rt && xo == XOP_DIVU
        && issue.opb != ZERO32 |-> ##33 result.wr
        && result.data == $past(issue.opa, 33) / $past(issue.opb, 33))
        else $error("unsigned quotient wrong");
    chk_cust_launch: assert property (tk && op == OP_CUSTOM |=> cust_start && busy
        && cust_req.sel == $past(issue.word[13:6]) && cust_req.gpa == $past(issue.word[16])
        && cust_req.gpc == $past(issue.word[14]) && cust_req.opa == $past(issue.opa))
        else $error("custom dispatch wrong");
    chk_cust_writeback: assert property (busy && cust_done && !cust_start
        |=> result.wr == $past(wp) && !busy) else $error("custom write-back wrong");
    chk_reg_not_equal: assert property (rt && xo == XOP_CMPNE |=> result.wr
        && result.data == {31'h0, $past(ne)}) else $error("register not-equal wrong");
    chk_div_quotient: assert property (HAS_DIV && rt && xo == XOP_DIV
        && issue.opb != ZERO32 && !(issue.opa == 32'h8000_0000 && issue.opb == 32'hFFFF_FFFF)
        |-> ##33 result.wr && result.data == $past(sq, 33)) else $error("signed quotient wrong");
    chk_divu_zero: assert property (HAS_DIVU && rt && xo == XOP_DIVU
        && issue.opb == ZERO32 |-> ##33 result.wr && !result.unimpl)
        else $error("divide by zero misbehaved");
    chk_div_absent: assert property ((!HAS_DIVU && rt && xo == XOP_DIVU)
        || (!HAS_DIV && rt && xo == XOP_DIV) |=> result.unimpl && !result.wr && !busy)
        else $error("missing divider not flagged");
endmodule

bind compare_divide_custom_exec cmp_div_monitor #(.HAS_DIVU(HAS_DIVU), .HAS_DIV(HAS_DIV))
    u_mon (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid), .issue(issue), .busy(busy),
    .result(result), .cust_start(cust_start), .cust_req(cust_req), .cust_done(cust_done),
    .cust_has_result(cust_has_result), .cust_result(cust_result));

// ### bench/cust_logic_model.sv
// Behavioural custom logic answering a dispatch after a chosen delay
`timescale 1ns/100ps
module cust_logic_model
    import cmp_div_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         cust_start,
    input  wire cust_req_type cust_req,
    input  wire logic [3:0]   lat,
    output logic              cust_done,
    output logic              cust_has_result,
    output logic [31:0]       cust_result
);
    logic [4:0] cnt_ff;
    // Odd selectors give a result, even ones none; data toggles in every cycle except the answer cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff          <= 5'h00;
            cust_done       <= 1'b0;
            cust_has_result <= 1'b0;
            cust_result     <= 32'h0000_0000;
        end else begin
            cnt_ff          <= cust_start ? {1'b0, lat} + 5'h01 : cnt_ff - {4'h0, |cnt_ff};
            cust_done       <= cnt_ff == 5'h01;
            cust_has_result <= cnt_ff == 5'h01 && cust_req.sel[0];
            cust_result     <= (cnt_ff == 5'h01) ? cust_req.opa + cust_req.opb
                               + {24'h0, cust_req.sel} : ~cust_result;
        end
    end
endmodule

// ### bench/compare_divide_custom_exec_bench.sv
// Self-checking bench for the compare, divide and custom dispatch unit
`timescale 1ns/100ps
module compare_divide_custom_exec_bench import cmp_div_pkg::*;;
    logic clk, rst_b, issue_valid, busy, cust_start, cust_done, cust_has_result, ub;
    issue_type    issue;
    result_type   result, result_b;
    cust_req_type cust_req;
    logic [31:0]  cust_result;
    logic [3:0]   lat;
    int           err_total, total_checks, cycles, n;
    logic [31:0]  va [4] = '{32'h8000_0000, 32'h1, 32'h5, 32'hFFFF_FFFF};
    logic [31:0]  vb [4] = '{32'h1, 32'h8000_0000, 32'h5, 32'h0};
    logic [15:0]  vi [4] = '{16'hFFFF, 16'h8000, 16'h0005, 16'hFFFF};
    compare_divide_custom_exec i_dut (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
        .issue(issue), .busy(busy), .result(result), .cust_start(cust_start),
        .cust_req(cust_req), .cust_done(cust_done), .cust_has_result(cust_has_result),
        .cust_result(cust_result));
    // Core built without divide hardware
    compare_divide_custom_exec #(.HAS_DIVU(1'b0), .HAS_DIV(1'b0)) i_bare (.clk(clk),
        .rst_b(rst_b), .issue_valid(issue_valid), .issue(issue), .busy(), .result(result_b),
        .cust_start(), .cust_req(), .cust_done(1'b0), .cust_has_result(1'b0),
        .cust_result(32'h0));
    cust_logic_model i_cust (.clk(clk), .rst_b(rst_b), .cust_start(cust_start),
        .cust_req(cust_req), .lat(lat), .cust_done(cust_done),
        .cust_has_result(cust_has_result), .cust_result(cust_result));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Issue one word, then wait a bounded time for a write or exception
    task automatic go(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
        @(posedge clk);
        #1;
        issue_valid = 1'b1;
        issue = '{w, a, b};
        @(posedge clk);
        #1;
        issue_valid = 1'b0;
        ub = result_b.unimpl;
        n = 1;
        while (result.wr !== 1'b1 && result.unimpl !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic sc_reg_cmp;
        for (int i = 0; i < 4; i++) begin
            go({5'h01, 5'h02, 5'h03, XOP_CMPLT, 5'h00, OP_RTYPE}, va[i], vb[i]);
            chk(result.data, {31'h0, $signed(va[i]) < $signed(vb[i])});
            chk(result.dst, 5'h03);
            chk(n, 1);
            go({5'h04, 5'h05, 5'h06, XOP_CMPLTU, 5'h00, OP_RTYPE}, va[i], vb[i]);
            chk(result.data, {31'h0, va[i] < vb[i]});
            go({5'h07, 5'h08, 5'h09, XOP_CMPNE, 5'h00, OP_RTYPE}, va[i], vb[i]);
            chk(result.data, {31'h0, va[i] != vb[i]});
        end
    endtask
    task automatic sc_imm_cmp;
        for (int i = 0; i < 4; i++) begin
            go({5'h0A, 5'h0B, vi[i], OP_CMPLTI}, va[i], 32'h0);
            chk(result.data, {31'h0, $signed(va[i]) < $signed({{16{vi[i][15]}}, vi[i]})});
            chk(result.dst, 5'h0B);
            go({5'h0A, 5'h0C, vi[i], OP_CMPLTUI}, va[i], 32'h0);
            chk(result.data, {31'h0, va[i] < {16'h0, vi[i]}});
            go({5'h0A, 5'h0D, vi[i], OP_CMPNEI}, va[i], 32'h0);
            chk(result.data, {31'h0, va[i] != {{16{vi[i][15]}}, vi[i]}});
        end
    endtask
    task automatic sc_div;
        go({5'h01, 5'h02, 5'h03, XOP_DIVU, 5'h00, OP_RTYPE}, 32'hFFFF_FFFF, 32'h7);
        chk(result.data, 32'h2492_4924);
        chk(n, 33);
        chk(ub, 1'b1);
        go({5'h01, 5'h02, 5'h03, XOP_DIV, 5'h00, OP_RTYPE}, 32'h64, 32'hFFFF_FFF9);
        chk(result.data, 32'hFFFF_FFF2);
        chk(ub, 1'b1);
        go({5'h01, 5'h02, 5'h03, XOP_DIVU, 5'h00, OP_RTYPE}, 32'h64, 32'h0);
        chk(result.unimpl, 1'b0);
        chk(n, 33);
    endtask
    // Only selector A1 written to a general register returns a value
    task automatic sc_custom;
        for (int i = 0; i < 4; i++) begin
            lat = 4'(i * 5);
            go({5'h01, 5'h02, 5'h03, i[0], i[1], i != 2, 8'hA1 + 8'(i), OP_CUSTOM},
               32'h10, 32'h20);
            chk(cust_req.sel, 8'hA1 + 8'(i));
            chk({cust_req.gpa, cust_req.gpb, cust_req.ic}, {i[0], i[1], 5'h03});
            chk(result.wr, i == 0);
            if (i == 0) chk(result.data, 32'hD1);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Run length guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out;
        end
    end
    initial begin
        rst_b = 1'b0;
        issue_valid = 1'b0;
        issue = '0;
        lat = 4'h0;
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        sc_reg_cmp;
        sc_imm_cmp;
        sc_div;
        sc_custom;
        close_out;
    end
endmodule
